// >>> core/agu_ea_calc.sv
// effective address calculator: address modes, pointer updates and direct register access
`timescale 1ns/1ps
module agu_ea_calc
  import agu_pkg::*;
(
  // clock and reset
  input  wire logic    clk_i,
  input  wire logic    rst_n_i,
  // decoder request
  input  wire logic    req_valid_i,
  output logic         req_ready_o,
  input  wire ea_req_s req_i,
  // mode
  input  wire logic    sixteen_bit_compat_i,
  // result towards address buses
  output logic         result_valid_o,
  output ea_result_s   result_o
);

  typedef enum logic {ST_IDLE, ST_CALC} state_e;

  state_e     state_reg, state_next;
  ea_req_s    req_reg, req_next;
  ea_result_s result_reg, result_next;
  logic       valid_reg, valid_next;
  triplet_s   trip;
  logic       wr_en;
  bank_e      wr_bank;
  logic [2:0] wr_idx;
  word_t      wr_data;
  word_t      off_sx;
  word_t      step;
  logic       step_neg;
  word_t      upd;
  word_t      disp;
  logic       sc;

  // ==========================================================
  // helpers
  function automatic word_t rev24(input word_t v);
    word_t r;
    for (int i = 0; i < ADDR_W; i++) begin
      r[i] = v[ADDR_W-1-i];
    end
    return r;
  endfunction

  function automatic word_t sext(input logic [FIELD_W-1:0] f, input int bits);
    word_t v;
    v = {{(ADDR_W-FIELD_W){1'b0}}, f};
    for (int i = 0; i < ADDR_W; i++) begin
      if (i >= bits) begin
        v[i] = f[bits-1];
      end
    end
    return v;
  endfunction

  function automatic word_t zext(input logic [FIELD_W-1:0] f, input int bits);
    word_t v;
    v = '0;
    for (int i = 0; i < FIELD_W; i++) begin
      if (i < bits) begin
        v[i] = f[i];
      end
    end
    return v;
  endfunction

  function automatic word_t sc_clip(input word_t v, input logic c);
    return c ? {{(ADDR_W-SC_KEEP_W){1'b0}}, v[SC_KEEP_W-1:0]} : v;
  endfunction

  // pointer arithmetic picked by the modifier; modulo assumes |step| <= modulus
  function automatic word_t agu_add(input word_t r, input word_t s, input logic neg, input word_t m);
    word_t sum;
    word_t mask;
    word_t base;
    word_t size;
    sum  = r + s;
    mask = '0;
    if (m[15:0] == MOD_LINEAR) begin
      return sum;
    end else if (m[15:0] == MOD_REVERSE) begin
      return rev24(rev24(r) + rev24(s));
    end else if (!m[MWRAP_SEL_BIT]) begin
      for (int i = 0; i < MOD_SIZE_W; i++) begin
        mask[i] = |(m[MOD_SIZE_W-1:0] >> i);
      end
      base = r & ~mask;
      size = {{(ADDR_W-MOD_SIZE_W){1'b0}}, m[MOD_SIZE_W-1:0]} + STEP_ONE;
      if (!neg && (sum > base + size - STEP_ONE)) begin
        return sum - size;
      end else if (neg && (sum < base)) begin
        return sum + size;
      end
      return sum;
    end else begin
      // several wraps are fine here: only the low bits move
      mask = {{(ADDR_W-MWRAP_MASK_W){1'b0}}, m[MWRAP_MASK_W-1:0]};
      return (r & ~mask) | (sum & mask);
    end
  endfunction

  // ==========================================================
  // register triplets
  agu_regfile u_regfile (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .rd_idx_i  (req_i.idx),
    .rd_data_o (trip),
    .wr_en_i   (wr_en),
    .wr_bank_i (wr_bank),
    .wr_idx_i  (wr_idx),
    .wr_data_i (wr_data)
  );

  assign sc = sixteen_bit_compat_i;

  // ==========================================================
  // update step
  always_comb begin
    // in compatibility mode the offset sign sits in bit 15
    off_sx   = trip.off;
    off_sx   = sc ? {{(ADDR_W-SC_KEEP_W){trip.off[SC_KEEP_W-1]}}, trip.off[SC_KEEP_W-1:0]} : off_sx;
    disp     = req_reg.mode == M_DISP_SHORT ? sext(req_reg.field, DISP_SHORT_W) : req_reg.ext;
    step     = '0;
    step_neg = 1'b0;
    case (req_reg.mode)
      M_POST_INC:   step = STEP_ONE;
      M_POST_DEC, M_PRE_DEC: begin
        step     = ~STEP_ONE + STEP_ONE;
        step_neg = 1'b1;
      end
      M_POST_INC_N, M_INDEXED: begin
        step     = off_sx;
        step_neg = off_sx[ADDR_W-1];
      end
      M_POST_DEC_N: begin
        step     = ~off_sx + STEP_ONE;
        step_neg = ~off_sx[ADDR_W-1];
      end
      M_DISP_SHORT, M_DISP_LONG: begin
        step     = disp;
        step_neg = disp[ADDR_W-1];
      end
      default: step = '0;
    endcase
    upd = sc_clip(agu_add(trip.ptr, step, step_neg, trip.mod), sc);
  end

  // ==========================================================
  // sequencing, write-back and result
  always_comb begin
    state_next  = state_reg;
    req_next    = req_reg;
    result_next = result_reg;
    valid_next  = 1'b0;
    wr_en       = 1'b0;
    wr_bank     = BANK_PTR;
    wr_idx      = req_reg.idx;
    wr_data     = upd;
    case (state_reg)
      ST_IDLE: begin
        if (req_valid_i) begin
          req_next   = req_i;
          state_next = ST_CALC;
        end
      end
      ST_CALC: begin
        state_next           = ST_IDLE;
        valid_next           = 1'b1;
        result_next          = '0;
        result_next.kind     = RES_MEM;
        result_next.space    = req_reg.space;
        result_next.dreg_sel = '0;
        case (req_reg.mode)
          M_DREG: begin
            result_next.kind     = RES_DREG;
            result_next.dreg_sel = req_reg.field;
          end
          M_AREG_RD: begin
            result_next.kind = RES_REG;
            case (req_reg.bank)
              BANK_OFF: result_next.value = trip.off;
              BANK_MOD: result_next.value = trip.mod;
              default:  result_next.value = trip.ptr;
            endcase
          end
          M_AREG_WR: begin
            result_next.kind = RES_REG;
            wr_en            = 1'b1;
            wr_bank          = req_reg.bank;
            wr_data          = sc_clip(req_reg.wdata, sc);
          end
          M_IND_NOUPD: result_next.value = sc_clip(trip.ptr, sc);
          M_POST_INC, M_POST_DEC, M_POST_INC_N, M_POST_DEC_N: begin
            result_next.value = sc_clip(trip.ptr, sc);
            wr_en             = 1'b1;
          end
          M_PRE_DEC: begin
            result_next.value = upd;
            wr_en             = 1'b1;
          end
          M_INDEXED, M_DISP_SHORT: result_next.value = upd;
          M_DISP_LONG: begin
            result_next.value    = upd;
            result_next.ext_used = 1'b1;
          end
          M_PC_SHORT: result_next.value = sc_clip(req_reg.pc + sext(req_reg.field, PC_DISP_W), sc);
          M_PC_LONG: begin
            result_next.value    = sc_clip(req_reg.pc + req_reg.ext, sc);
            result_next.ext_used = 1'b1;
          end
          M_PC_REG: result_next.value = sc_clip(req_reg.pc + trip.ptr, sc);
          M_IMM_LONG: begin
            result_next.kind     = RES_IMM;
            result_next.value    = req_reg.ext;
            result_next.ext_used = 1'b1;
          end
          M_IMM_BYTE: begin
            result_next.kind  = RES_IMM;
            result_next.value = zext(req_reg.field, IMM_BYTE_W);
          end
          M_IMM_LOOP: begin
            result_next.kind  = RES_IMM;
            result_next.value = zext(req_reg.field, IMM_LOOP_W);
          end
          M_ABS_LONG: begin
            result_next.value    = sc_clip(req_reg.ext, sc);
            result_next.ext_used = 1'b1;
          end
          M_ABS_SHORT: result_next.value = zext(req_reg.field, ABS_SHORT_W);
          M_JUMP_SHORT: begin
            result_next.space = SP_P;
            result_next.value = zext(req_reg.field, JUMP_SHORT_W);
          end
          M_IO_SHORT: begin
            result_next.value = sc_clip(~zext(~req_reg.field, IO_SHORT_W), sc);
          end
          default: result_next.kind = RES_IMPL;
        endcase
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg  <= ST_IDLE;
      req_reg    <= '0;
      result_reg <= '0;
      valid_reg  <= 1'b0;
    end else begin
      state_reg  <= state_next;
      req_reg    <= req_next;
      result_reg <= result_next;
      valid_reg  <= valid_next;
    end
  end

  assign req_ready_o    = state_reg == ST_IDLE;
  assign result_valid_o = valid_reg;
  assign result_o       = result_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence taken_s;
    req_valid_i && req_ready_o;
  endsequence

  sequence calc_s(ea_mode_e m);
    state_reg == ST_CALC && req_reg.mode == m && !sc;
  endsequence

  resp_timing_a: assert property (taken_s |=> !req_ready_o ##1 result_valid_o)
    else $error("result not two cycles after request");

  noupd_keep_a: assert property (calc_s(M_IND_NOUPD) |-> !wr_en ##1 result_o.value == $past(trip.ptr))
    else $error("no-update mode changed pointer or address");

  postinc_lin_a: assert property (calc_s(M_POST_INC) && trip.mod[15:0] == MOD_LINEAR
      |-> wr_en && wr_data == trip.ptr + STEP_ONE ##1 result_o.value == $past(trip.ptr))
    else $error("post-increment wrong");

  postdec_lin_a: assert property (calc_s(M_POST_DEC) && trip.mod[15:0] == MOD_LINEAR
      |-> wr_en && wr_data == trip.ptr - STEP_ONE)
    else $error("post-decrement wrong");

  indexed_keep_a: assert property (calc_s(M_INDEXED) && trip.mod[15:0] == MOD_LINEAR
      |-> !wr_en ##1 result_o.value == $past(trip.ptr) + $past(trip.off))
    else $error("indexed address wrong");

  predec_addr_a: assert property (state_reg == ST_CALC && req_reg.mode == M_PRE_DEC
      |-> wr_en ##1 result_o.value == $past(wr_data))
    else $error("pre-decrement address differs from stored pointer");

  pc_short_a: assert property (calc_s(M_PC_SHORT)
      |=> result_o.value == $past(req_reg.pc) + sext($past(req_reg.field), PC_DISP_W))
    else $error("short pc displacement wrong");

  io_short_a: assert property (calc_s(M_IO_SHORT)
      |=> result_o.value[ADDR_W-1:IO_SHORT_W] == '1)
    else $error("short i/o upper bits not set");

  sc_clear_a: assert property (state_reg == ST_CALC && sc && req_reg.mode inside {M_INDEXED, M_PC_LONG, M_PRE_DEC}
      |=> result_o.value[ADDR_W-1:SC_KEEP_W] == '0)
    else $error("compatibility mode upper bits not cleared");

  revcarry_a: assert property (calc_s(M_POST_INC) && trip.mod[15:0] == MOD_REVERSE
      |-> wr_data == rev24(rev24(trip.ptr) + rev24(STEP_ONE)))
    else $error("reverse-carry update wrong");

endmodule

// >>> core/agu_pkg.sv
// package: constants, modes and carriers of the effective address calculator
package agu_pkg;

  // ==========================================================
  // widths and field positions
  localparam int ADDR_W        = 24;
  localparam int NUM_TRIP      = 8;
  localparam int FIELD_W       = 12;
  localparam int SC_KEEP_W     = 16;
  localparam int DISP_SHORT_W  = 7;
  localparam int PC_DISP_W     = 9;
  localparam int IMM_BYTE_W    = 8;
  localparam int IMM_LOOP_W    = 12;
  localparam int ABS_SHORT_W   = 6;
  localparam int IO_SHORT_W    = 6;
  localparam int JUMP_SHORT_W  = 12;
  localparam int MWRAP_SEL_BIT = 15;
  localparam int MWRAP_KEY_BIT = 14;
  localparam int MWRAP_MASK_W  = 14;
  localparam int MOD_SIZE_W    = 15;

  // ==========================================================
  // reset values and modifier codes
  localparam logic [23:0] PTR_RST     = 24'h000000;
  localparam logic [23:0] OFF_RST     = 24'h000000;
  localparam logic [23:0] MOD_RST     = 24'hffffff;
  localparam logic [15:0] MOD_LINEAR  = 16'hffff;
  localparam logic [15:0] MOD_REVERSE = 16'h0000;
  localparam logic [23:0] STEP_ONE    = 24'h000001;

  typedef logic [ADDR_W-1:0] word_t;

  // ==========================================================
  // modes, spaces and carriers
  typedef enum logic [4:0] {
    M_DREG, M_AREG_RD, M_AREG_WR, M_IND_NOUPD, M_POST_INC, M_POST_DEC,
    M_POST_INC_N, M_POST_DEC_N, M_INDEXED, M_PRE_DEC, M_DISP_SHORT,
    M_DISP_LONG, M_PC_SHORT, M_PC_LONG, M_PC_REG, M_IMM_LONG, M_IMM_BYTE,
    M_IMM_LOOP, M_ABS_LONG, M_ABS_SHORT, M_JUMP_SHORT, M_IO_SHORT, M_IMPLICIT
  } ea_mode_e;

  typedef enum logic [1:0] {SP_X, SP_Y, SP_P, SP_L} space_e;
  typedef enum logic [1:0] {BANK_PTR, BANK_OFF, BANK_MOD} bank_e;
  typedef enum logic [2:0] {RES_MEM, RES_IMM, RES_REG, RES_DREG, RES_IMPL} res_kind_e;

  typedef struct packed {
    ea_mode_e           mode;
    space_e             space;
    bank_e              bank;
    logic [2:0]         idx;
    logic [FIELD_W-1:0] field;
    word_t              ext;
    word_t              pc;
    word_t              wdata;
  } ea_req_s;

  typedef struct packed {
    res_kind_e          kind;
    space_e             space;
    logic               ext_used;
    logic [FIELD_W-1:0] dreg_sel;
    word_t              value;
  } ea_result_s;

  typedef struct packed {
    word_t ptr;
    word_t off;
    word_t mod;
  } triplet_s;

endpackage

// >>> core/agu_regfile.sv
// register triplet file: pointers, offsets and modifiers with a registered read port
`timescale 1ns/1ps
module agu_regfile
  import agu_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // read port
  input  wire logic [2:0] rd_idx_i,
  output triplet_s        rd_data_o,
  // write port
  input  wire logic       wr_en_i,
  input  wire bank_e      wr_bank_i,
  input  wire logic [2:0] wr_idx_i,
  input  wire word_t      wr_data_i
);

  logic [NUM_TRIP-1:0][ADDR_W-1:0] ptr_reg, ptr_next;
  logic [NUM_TRIP-1:0][ADDR_W-1:0] off_reg, off_next;
  logic [NUM_TRIP-1:0][ADDR_W-1:0] mod_reg, mod_next;
  triplet_s                        rd_reg, rd_next;

  // ==========================================================
  // next state
  always_comb begin
    ptr_next = ptr_reg;
    off_next = off_reg;
    mod_next = mod_reg;
    if (wr_en_i) begin
      case (wr_bank_i)
        BANK_PTR: ptr_next[wr_idx_i] = wr_data_i;
        BANK_OFF: off_next[wr_idx_i] = wr_data_i;
        BANK_MOD: mod_next[wr_idx_i] = wr_data_i;
        default:  ptr_next = ptr_reg;
      endcase
    end
    // read sees the old value; the calculator never reads in a write cycle
    rd_next = '{ptr: ptr_reg[rd_idx_i], off: off_reg[rd_idx_i], mod: mod_reg[rd_idx_i]};
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ptr_reg <= {NUM_TRIP{PTR_RST}};
      off_reg <= {NUM_TRIP{OFF_RST}};
      mod_reg <= {NUM_TRIP{MOD_RST}};
      rd_reg  <= '0;
    end else begin
      ptr_reg <= ptr_next;
      off_reg <= off_next;
      mod_reg <= mod_next;
      rd_reg  <= rd_next;
    end
  end

  assign rd_data_o = rd_reg;

endmodule

// >>> verif/ea_decoder_model.sv
// instruction decoder model: presents requests and collects results
`timescale 1ns/1ps
module ea_decoder_model
  import agu_pkg::*;
(
  // clock
  input  wire logic       clk_i,
  // request side
  output logic            req_valid_o,
  input  wire logic       req_ready_i,
  output ea_req_s         req_o,
  // result side
  input  wire logic       result_valid_i,
  input  wire ea_result_s result_i
);
  initial begin
    req_valid_o = 1'b0;
    req_o       = '0;
  end

  // ==========================================================
  // one transfer: held until the edge that samples ready high
  task automatic issue(input ea_req_s r, output ea_result_s res);
    int n;
    @(posedge clk_i);
    req_valid_o <= 1'b1;
    req_o       <= r;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (req_ready_i !== 1'b1 && n < 64);
    @(posedge clk_i);
    req_valid_o <= 1'b0;
    // released fields carry the inverse so a stale value cannot pass
    req_o       <= ~r;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (result_valid_i !== 1'b1 && n < 64);
    res = result_i;
  endtask
endmodule

// >>> verif/effective_address_calculator_test.sv
// self-checking bench of the effective address calculator
`timescale 1ns/1ps
module effective_address_calculator_test import agu_pkg::*;;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       compat = 1'b0;
  logic       req_valid;
  logic       req_ready;
  logic       result_valid;
  ea_req_s    req;
  ea_result_s res;
  ea_result_s r;
  word_t      pc_v = 24'h000000;
  int         errors = 0;
  int         cmp_count = 0;
  int         cycles = 0;

  always #2.5 clk = ~clk;

  agu_ea_calc dut (.clk_i(clk), .rst_n_i(rst_n), .req_valid_i(req_valid), .req_ready_o(req_ready),
                   .req_i(req), .sixteen_bit_compat_i(compat), .result_valid_o(result_valid),
                   .result_o(res));
  ea_decoder_model u_dec (.clk_i(clk), .req_valid_o(req_valid), .req_ready_i(req_ready), .req_o(req),
                          .result_valid_i(result_valid), .result_i(res));

  // ==========================================================
  // shared helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic op(input ea_mode_e m, input logic [2:0] i, input logic [11:0] f, input word_t e,
                    input bank_e b = BANK_PTR, input word_t w = 24'h000000);
    u_dec.issue(ea_req_s'{mode: m, space: SP_X, bank: b, idx: i, field: f, ext: e, pc: pc_v, wdata: w}, r);
  endtask

  task automatic wr(input bank_e b, input logic [2:0] i, input word_t w);
    op(M_AREG_WR, i, 12'h000, 24'h000000, b, w);
  endtask

  task automatic rd(input bank_e b, input logic [2:0] i);
    op(M_AREG_RD, i, 12'h000, 24'h000000, b);
  endtask

  task automatic conclude();
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      rd(BANK_MOD, 3'(i));
      check(r.value, 24'hffffff);
      rd(BANK_PTR, 3'(i));
      check({r.kind, r.value}, {RES_REG, 24'h000000});
    end
  endtask

  task automatic t_update();
    ea_mode_e m[7] = '{M_IND_NOUPD, M_POST_INC, M_POST_DEC, M_POST_INC_N, M_POST_DEC_N, M_INDEXED, M_PRE_DEC};
    word_t a[7] = '{24'h00fff0, 24'h00fff0, 24'h00fff1, 24'h00fff0, 24'h010000, 24'h010000, 24'h00ffef};
    word_t p[7] = '{24'h00fff0, 24'h00fff1, 24'h00fff0, 24'h010000, 24'h00fff0, 24'h00fff0, 24'h00ffef};
    wr(BANK_PTR, 3'h5, 24'h00fff0);
    wr(BANK_OFF, 3'h5, 24'h000010);
    // upper byte of the modifier set on purpose: only the low 16 bits decide
    wr(BANK_MOD, 3'h5, 24'h12ffff);
    for (int k = 0; k < 7; k++) begin
      op(m[k], 3'h5, 12'h000, 24'h000000);
      check({r.kind, r.value}, {RES_MEM, a[k]});
      rd(BANK_PTR, 3'h5);
      check(r.value, p[k]);
    end
    rd(BANK_OFF, 3'h5);
    check(r.value, 24'h000010);
    wr(BANK_PTR, 3'h5, 24'hffffff);
    op(M_POST_INC, 3'h5, 12'h000, 24'h000000);
    rd(BANK_PTR, 3'h5);
    check(r.value, 24'h000000);
  endtask

  task automatic t_reverse();
    wr(BANK_MOD, 3'h2, 24'h000000);
    wr(BANK_OFF, 3'h2, 24'h800000);
    op(M_POST_INC_N, 3'h2, 12'h000, 24'h000000);
    rd(BANK_PTR, 3'h2);
    check(r.value, 24'h800000);
    op(M_POST_INC_N, 3'h2, 12'h000, 24'h000000);
    rd(BANK_PTR, 3'h2);
    check(r.value, 24'h400000);
    op(M_DISP_LONG, 3'h2, 12'h000, 24'hc00000);
    check({r.ext_used, r.value}, {1'b1, 24'ha00000});
    // linear sum wraps to zero where a reverse carry would not
    pc_v = 24'hc00000;
    op(M_PC_REG, 3'h2, 12'h000, 24'h000000);
    check(r.value, 24'h000000);
    rd(BANK_PTR, 3'h2);
    check(r.value, 24'h400000);
    // plus one under reverse carry: the reversed step enters at the top bit
    op(M_POST_INC, 3'h2, 12'h000, 24'h000000);
    rd(BANK_PTR, 3'h2);
    check(r.value, 24'h400001);
  endtask

  task automatic t_disp_pc();
    wr(BANK_PTR, 3'h1, 24'h000100);
    op(M_DISP_SHORT, 3'h1, 12'hf40, 24'h000000);
    check(r.value, 24'h0000c0);
    op(M_DISP_SHORT, 3'h1, 12'h03f, 24'h000000);
    check(r.value, 24'h00013f);
    op(M_DISP_LONG, 3'h1, 12'h000, 24'hfffff0);
    check({r.ext_used, r.value}, {1'b1, 24'h0000f0});
    rd(BANK_PTR, 3'h1);
    check(r.value, 24'h000100);
    pc_v = 24'h001000;
    op(M_PC_SHORT, 3'h1, 12'h100, 24'h000000);
    check(r.value, 24'h000f00);
    op(M_PC_LONG, 3'h1, 12'h000, 24'h000234);
    check({r.ext_used, r.value}, {1'b1, 24'h001234});
  endtask

  task automatic t_special();
    ea_mode_e m[7] = '{M_IMM_BYTE, M_IMM_LOOP, M_IMM_LONG, M_ABS_LONG, M_ABS_SHORT, M_JUMP_SHORT, M_IO_SHORT};
    logic [11:0] f[7] = '{12'hfa5, 12'hfa5, 12'h000, 12'h000, 12'hfff, 12'hfff, 12'h0c5};
    word_t e[7] = '{24'h000000, 24'h000000, 24'habcdef, 24'h123456, 24'h000000, 24'h000000, 24'h000000};
    logic [24:0] x[7] = '{{1'b0, 24'h0000a5}, {1'b0, 24'h000fa5}, {1'b1, 24'habcdef}, {1'b1, 24'h123456},
                          {1'b0, 24'h00003f}, {1'b0, 24'h000fff}, {1'b0, 24'hffffc5}};
    for (int k = 0; k < 7; k++) begin
      op(m[k], 3'h0, f[k], e[k]);
      check({r.ext_used, r.value}, x[k]);
    end
    check(r.kind, RES_MEM);
    op(M_JUMP_SHORT, 3'h0, 12'h800, 24'h000000);
    check({r.space, r.value}, {SP_P, 24'h000800});
    op(M_IMM_BYTE, 3'h0, 12'h0ff, 24'h000000);
    check(r.kind, RES_IMM);
  endtask

  task automatic t_direct();
    op(M_DREG, 3'h0, 12'h5a3, 24'h000000);
    check({r.kind, r.dreg_sel}, {RES_DREG, 12'h5a3});
    op(M_IMPLICIT, 3'h0, 12'h000, 24'h000000);
    check({r.kind, r.value}, {RES_IMPL, 24'h000000});
    // memory space must follow the request, not sit at its reset value
    u_dec.issue(ea_req_s'{mode: M_ABS_SHORT, space: SP_Y, bank: BANK_PTR, idx: 3'h0, field: 12'h015,
                          ext: 24'h000000, pc: pc_v, wdata: 24'h000000}, r);
    check({r.space, r.value}, {SP_Y, 24'h000015});
    wr(BANK_OFF, 3'h7, 24'h5a5a5a);
    check({r.kind, r.value}, {RES_REG, 24'h000000});
    wr(BANK_MOD, 3'h7, 24'h00a5a5);
    rd(BANK_OFF, 3'h7);
    check(r.value, 24'h5a5a5a);
    rd(BANK_MOD, 3'h7);
    check(r.value, 24'h00a5a5);
  endtask

  task automatic t_compat();
    @(posedge clk);
    compat <= 1'b1;
    wr(BANK_PTR, 3'h1, 24'h000000);
    op(M_ABS_LONG, 3'h1, 12'h000, 24'habcdef);
    check(r.value, 24'h00cdef);
    op(M_IO_SHORT, 3'h1, 12'h03f, 24'h000000);
    check(r.value, 24'h00ffff);
    op(M_DISP_SHORT, 3'h1, 12'h07f, 24'h000000);
    check(r.value, 24'h00ffff);
    pc_v = 24'h00ff00;
    op(M_PC_LONG, 3'h1, 12'h000, 24'h000200);
    check(r.value, 24'h000100);
    @(posedge clk);
    compat <= 1'b0;
  endtask

  // ==========================================================
  // main sequence and hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 5000) begin
      errors++;
      conclude();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_update();
    t_reverse();
    t_disp_pc();
    t_special();
    t_direct();
    t_compat();
    conclude();
  end
endmodule
